/* pkg/host_port_pkg.sv */
`default_nettype none
package host_port_pkg;
	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int STAT_RX = 0;
	localparam int STAT_TX = 1;
	localparam int STAT_DMA = 2;
	localparam int STAT_W = 3;

	// ----------------------------------------
	// register select code of the status register
	// ----------------------------------------
	localparam logic [3:0] SEL_IRQ_STATUS = 4'h7;

	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [STAT_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [3:0] SELECT_RESET = 4'h0;
	localparam logic [1:0] LATCH_HOLD_CYCLES = 2'h2;
	localparam logic [1:0] COUNT_RESET = 2'h0;
	localparam logic [7:0] READ_RESET = 8'h00;

	typedef enum logic [1:0] {
		LW_IDLE = 2'b00,
		LW_ENABLE = 2'b01,
		LW_RELEASE = 2'b10
	} latch_state_t;

	typedef struct packed {
		logic [STAT_W-1:0] status;
		logic wr_prev;
		logic ack_prev;
		latch_state_t lw;
		logic [1:0] cnt;
		logic [7:0] rd_data;
		logic rd_oe;
		logic irq;
		logic latch_oe;
		logic mem_wr;
	} port_state_t;

	typedef struct packed {
		logic [3:0] held;
	} select_state_t;
endpackage
`default_nettype wire

/* rtl/host_slave_port.sv */
`timescale 1ns/1ps
`default_nettype none
module host_slave_port (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic RX_DONE,
	input wire logic TX_DONE,
	input wire logic DMA_DONE,
	input wire logic [2:0] IRQ_ENABLE,
	output logic IRQ,
	input wire logic DEVICE_SELECT_N,
	input wire logic DMA_ACTIVE,
	input wire logic ADDRESS_LATCH_STROBE,
	input wire logic [3:0] REG_SELECT,
	input wire logic SLAVE_READ_STROBE_N,
	input wire logic SLAVE_WRITE_STROBE_N,
	input wire logic [15:0] MUXED_BUS_IN,
	output logic [15:0] MUXED_BUS_OUT,
	output logic [15:0] MUXED_BUS_OE_N,
	input wire logic LATCH_WRITE_ACK,
	output logic LATCH_OUTPUT_ENABLE_N,
	output logic MEM_WRITE_N
);
	host_port_pkg::port_state_t s;
	host_port_pkg::port_state_t next_s;
	logic slave;
	logic [3:0] sel;
	logic wr_hit;
	logic rd_hit;
	logic [2:0] set_bits;
	logic [2:0] clr_bits;
	logic ack_rise;

	function automatic logic is_status_sel(input logic [3:0] code);
		return code == host_port_pkg::SEL_IRQ_STATUS;
	endfunction

	// ----------------------------------------
	// slave decode
	// ----------------------------------------
	assign slave = !DEVICE_SELECT_N && !DMA_ACTIVE;

	select_latch u_select (
		.clk(CLK),
		.rstn(RSTN),
		.slave(slave),
		.strobe(ADDRESS_LATCH_STROBE),
		.sel_in(REG_SELECT),
		.sel_out(sel)
	);

	// write taken once, on the strobe's falling cycle
	assign wr_hit = slave && !SLAVE_WRITE_STROBE_N && s.wr_prev && is_status_sel(sel);
	assign rd_hit = slave && !SLAVE_READ_STROBE_N && is_status_sel(sel);
	assign set_bits = {DMA_DONE, TX_DONE, RX_DONE};
	assign clr_bits = wr_hit ? MUXED_BUS_IN[2:0] : 3'h0;
	assign ack_rise = LATCH_WRITE_ACK && !s.ack_prev;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.wr_prev = SLAVE_WRITE_STROBE_N;
		next_s.ack_prev = LATCH_WRITE_ACK;
		// set beats clear so an event in the clearing cycle survives
		next_s.status = (s.status & ~clr_bits) | set_bits;
		next_s.irq = |(s.status & IRQ_ENABLE);
		next_s.rd_oe = rd_hit;
		next_s.rd_data = {5'h00, s.status};
		case (s.lw)
			host_port_pkg::LW_IDLE: begin
				// an acknowledge during a cycle in flight is not queued
				if (ack_rise) begin
					next_s.lw = host_port_pkg::LW_ENABLE;
					next_s.latch_oe = 1'b1;
					next_s.cnt = host_port_pkg::COUNT_RESET;
				end
			end
			host_port_pkg::LW_ENABLE: begin
				next_s.mem_wr = 1'b1;
				next_s.cnt = 2'(s.cnt + 2'h1);
				if (s.cnt == host_port_pkg::LATCH_HOLD_CYCLES) begin
					next_s.mem_wr = 1'b0;
					next_s.lw = host_port_pkg::LW_RELEASE;
				end
			end
			host_port_pkg::LW_RELEASE: begin
				// latch held one cycle past the strobe for data hold
				next_s.latch_oe = 1'b0;
				next_s.lw = host_port_pkg::LW_IDLE;
			end
			default: begin
				next_s.lw = host_port_pkg::LW_IDLE;
				next_s.latch_oe = 1'b0;
				next_s.mem_wr = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			s.status <= host_port_pkg::STATUS_RESET;
			s.wr_prev <= 1'b1;
			s.ack_prev <= 1'b0;
			s.lw <= host_port_pkg::LW_IDLE;
			s.cnt <= host_port_pkg::COUNT_RESET;
			s.rd_data <= host_port_pkg::READ_RESET;
			s.rd_oe <= 1'b0;
			s.irq <= 1'b0;
			s.latch_oe <= 1'b0;
			s.mem_wr <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign IRQ = s.irq;
	assign MUXED_BUS_OUT = {8'h00, s.rd_data};
	assign MUXED_BUS_OE_N = {8'hFF, {8{!s.rd_oe}}};
	assign LATCH_OUTPUT_ENABLE_N = !s.latch_oe;
	assign MEM_WRITE_N = !s.mem_wr;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	event_sets_a: assert property (@(posedge CLK) disable iff (!RSTN)
		RX_DONE |=> s.status[host_port_pkg::STAT_RX] ##1 (IRQ || !$past(IRQ_ENABLE[0])))
		else $error("rx event did not reach status");

	clear_write_a: assert property (@(posedge CLK) disable iff (!RSTN)
		wr_hit && MUXED_BUS_IN[1] && !TX_DONE |=> !s.status[host_port_pkg::STAT_TX])
		else $error("status write did not clear bit");

	set_wins_a: assert property (@(posedge CLK) disable iff (!RSTN)
		clr_bits[0] && RX_DONE |=> s.status[host_port_pkg::STAT_RX])
		else $error("event lost to clear");

	masked_quiet_a: assert property (@(posedge CLK) disable iff (!RSTN)
		((s.status & IRQ_ENABLE) == 3'h0) |=> !IRQ)
		else $error("disabled source raised interrupt");

	irq_holds_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(|(s.status & IRQ_ENABLE)) |=> IRQ)
		else $error("interrupt dropped with enabled bit set");

	ack_starts_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(s.lw == host_port_pkg::LW_IDLE) && ack_rise |=> !LATCH_OUTPUT_ENABLE_N ##1 !MEM_WRITE_N [*2]
		##1 (MEM_WRITE_N && !LATCH_OUTPUT_ENABLE_N) ##1 LATCH_OUTPUT_ENABLE_N)
		else $error("acknowledge did not start write");

	oe_covers_a: assert property (@(posedge CLK) disable iff (!RSTN)
		$rose(MEM_WRITE_N) |-> !LATCH_OUTPUT_ENABLE_N && !$past(LATCH_OUTPUT_ENABLE_N))
		else $error("latch not enabled across write");

	read_drive_a: assert property (@(posedge CLK) disable iff (!RSTN)
		rd_hit |=> MUXED_BUS_OE_N == 16'hFF00 && MUXED_BUS_OUT[2:0] == $past(s.status))
		else $error("status read not driven on low byte");

	upper_float_a: assert property (@(posedge CLK) disable iff (!RSTN)
		MUXED_BUS_OE_N[15:8] == 8'hFF)
		else $error("upper byte driven");

	deselect_a: assert property (@(posedge CLK) disable iff (!RSTN)
		DEVICE_SELECT_N |=> MUXED_BUS_OE_N == 16'hFFFF)
		else $error("bus driven while deselected");

	dma_ignored_a: assert property (@(posedge CLK) disable iff (!RSTN)
		DMA_ACTIVE |=> MUXED_BUS_OE_N == 16'hFFFF)
		else $error("bus driven while dma active");

	write_once_a: assert property (@(posedge CLK) disable iff (!RSTN)
		wr_hit |=> !wr_hit)
		else $error("one strobe taken twice");

	status_frozen_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!slave && !(|set_bits) |=> s.status == $past(s.status))
		else $error("status changed outside slave mode");

	idle_quiet_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(s.lw == host_port_pkg::LW_IDLE) && !ack_rise |=> LATCH_OUTPUT_ENABLE_N && MEM_WRITE_N)
		else $error("write started without acknowledge");

	write_inside_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!MEM_WRITE_N |-> !LATCH_OUTPUT_ENABLE_N)
		else $error("memory write without latch enable");

	release_ends_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(s.lw == host_port_pkg::LW_RELEASE) |=> (s.lw == host_port_pkg::LW_IDLE) && LATCH_OUTPUT_ENABLE_N)
		else $error("latch not released after write");

	mem_in_enable_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!MEM_WRITE_N |-> s.lw == host_port_pkg::LW_ENABLE)
		else $error("memory write outside write state");

	read_release_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!rd_hit |=> MUXED_BUS_OE_N[7:0] == 8'hFF)
		else $error("low byte driven without read");

	tx_raises_irq_a: assert property (@(posedge CLK) disable iff (!RSTN)
		TX_DONE && IRQ_ENABLE[1] ##1 IRQ_ENABLE[1] |=> IRQ)
		else $error("tx event did not raise interrupt");

	dma_raises_irq_a: assert property (@(posedge CLK) disable iff (!RSTN)
		DMA_DONE && IRQ_ENABLE[2] ##1 IRQ_ENABLE[2] |=> IRQ)
		else $error("dma event did not raise interrupt");
endmodule // host_slave_port
`default_nettype wire

/* rtl/select_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module select_latch (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slave,
	input wire logic strobe,
	input wire logic [3:0] sel_in,
	output logic [3:0] sel_out
);
	host_port_pkg::select_state_t s;
	host_port_pkg::select_state_t next_s;

	// ----------------------------------------
	// flow-through while slave and strobe high, hold after its fall
	// ----------------------------------------
	always_comb begin
		next_s = s;
		if (slave && strobe) begin
			next_s.held = sel_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s.held <= host_port_pkg::SELECT_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign sel_out = (slave && strobe) ? sel_in : s.held;

	ignore_select_a: assert property (@(posedge clk) disable iff (!rstn)
		!slave ##1 !slave |-> $stable(sel_out))
		else $error("select changed outside slave mode");

	capture_fall_a: assert property (@(posedge clk) disable iff (!rstn)
		(slave && strobe) ##1 (slave && !strobe) |-> sel_out == $past(sel_in))
		else $error("select not captured at strobe fall");
endmodule // select_latch
`default_nettype wire

/* verification/host_slave_port_and_remote_write_latch_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module host_slave_port_and_remote_write_latch_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rx = 1'b0, tx = 1'b0, dma = 1'b0, load = 1'b0;
	logic sel_n = 1'b1, dma_act = 1'b0, als = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
	logic [2:0] en = 3'h7;
	logic [3:0] rsel = 4'h0;
	logic [15:0] host_d = 16'h0000, word = 16'h0000, bus_out, oe_n, q;
	logic irq, loe_n, mw_n, ack;
	int err_total = 0, n_checks = 0, cycles = 0;
	// ----------------------------------------
	// latch data reaches the bus only while its enable is low
	// ----------------------------------------
	wire logic [15:0] bus_in = loe_n ? host_d : q;
	always #5 clk = ~clk;
	host_slave_port i_dut (.CLK(clk), .RSTN(rstn), .RX_DONE(rx), .TX_DONE(tx), .DMA_DONE(dma),
		.IRQ_ENABLE(en), .IRQ(irq), .DEVICE_SELECT_N(sel_n), .DMA_ACTIVE(dma_act),
		.ADDRESS_LATCH_STROBE(als), .REG_SELECT(rsel), .SLAVE_READ_STROBE_N(rd_n),
		.SLAVE_WRITE_STROBE_N(wr_n), .MUXED_BUS_IN(bus_in), .MUXED_BUS_OUT(bus_out),
		.MUXED_BUS_OE_N(oe_n), .LATCH_WRITE_ACK(ack), .LATCH_OUTPUT_ENABLE_N(loe_n), .MEM_WRITE_N(mw_n));
	latch_glue i_glue (.clk(clk), .load(load), .word(word), .oe_n(loe_n), .ack(ack), .q(q));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(input logic [2:0] ev);
		{dma, tx, rx} = ev;
		ticks(1);
		{dma, tx, rx} = 3'h0;
		ticks(2);
	endtask
	task automatic access(input logic wr, sn, da, input logic [3:0] s, input logic [15:0] d, eo);
		sel_n = sn;
		dma_act = da;
		rsel = s;
		als = 1'b1;
		host_d = d;
		wr_n = ~wr;
		rd_n = wr;
		ticks(2);
		if (!wr) chk(oe_n, eo);
		if (!wr && eo == 16'hFF00) chk(bus_out, d);
		{wr_n, rd_n, sel_n, als, dma_act} = 5'h1C;
		ticks(2);
		chk(oe_n, 16'hFFFF);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_events;
		for (int i = 0; i < 3; i++) begin
			pulse(3'h1 << i);
			chk(irq, 1);
			access(1, 0, 0, 7, 16'h1 << i, 16'hFFFF);
			chk(irq, 0);
		end
		pulse(3'h7);
		access(1, 0, 0, 7, 16'h0001, 16'hFFFF);
		chk(irq, 1);
		access(0, 0, 0, 7, 16'h0006, 16'hFF00);
		access(1, 0, 0, 7, 16'h0006, 16'hFFFF);
		chk(irq, 0);
	endtask
	task automatic t_mask;
		en = 3'h5;
		pulse(3'h2);
		chk(irq, 0);
		access(0, 0, 0, 7, 16'h0002, 16'hFF00);
		en = 3'h7;
		ticks(3);
		chk(irq, 1);
		access(1, 0, 0, 7, 16'h0002, 16'hFFFF);
	endtask
	task automatic t_race;
		pulse(3'h1);
		sel_n = 1'b0;
		als = 1'b1;
		rsel = 4'h7;
		host_d = 16'h0001;
		wr_n = 1'b0;
		rx = 1'b1;
		ticks(1);
		wr_n = 1'b1;
		rx = 1'b0;
		sel_n = 1'b1;
		als = 1'b0;
		ticks(3);
		chk(irq, 1);
		access(1, 0, 0, 7, 16'h0001, 16'hFFFF);
		chk(irq, 0);
	endtask
	task automatic t_select;
		pulse(3'h1);
		access(1, 1, 0, 7, 16'h0001, 16'hFFFF);
		access(0, 1, 0, 7, 16'h0001, 16'hFFFF);
		access(1, 0, 1, 7, 16'h0001, 16'hFFFF);
		access(1, 0, 0, 3, 16'h0001, 16'hFFFF);
		chk(irq, 1);
		{sel_n, rsel, als} = 6'h0F;
		ticks(1);
		als = 1'b0;
		ticks(1);
		rsel = 4'h3;
		host_d = 16'h0001;
		wr_n = 1'b0;
		ticks(2);
		{wr_n, sel_n} = 2'h3;
		ticks(3);
		chk(irq, 0);
	endtask
	task automatic t_latch;
		logic [5:0] loe_exp = 6'h38, mw_exp = 6'h3C;
		{load, word} = 17'h1A55A;
		ticks(1);
		load = 1'b0;
		chk({loe_n, mw_n}, 16'h0003);
		ticks(1);
		chk({loe_n, mw_n}, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			load = (i == 1);
			ticks(1);
			chk({loe_n, mw_n}, {loe_exp[i], mw_exp[i]});
			if (!loe_n) chk(bus_in, 16'hA55A);
		end
		ticks(4);
		chk({loe_n, mw_n}, 16'h0003);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			results();
		end
	end
	initial begin
		ticks(20);
		rstn = 1'b1;
		ticks(1);
		chk(oe_n, 16'hFFFF);
		chk(bus_out, 16'h0000);
		chk({irq, loe_n, mw_n}, 16'h0003);
		t_events();
		t_mask();
		t_race();
		t_select();
		t_latch();
		results();
	end
endmodule // host_slave_port_and_remote_write_latch_bench
`default_nettype wire

/* verification/latch_glue.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// system side: external latch and its glue
// ----------------------------------------
module latch_glue (
	input wire logic clk,
	input wire logic load,
	input wire logic [15:0] word,
	input wire logic oe_n,
	output logic ack,
	output logic [15:0] q
);
	logic [15:0] held = 16'h0000;
	always @(posedge clk) begin
		if (load) held <= word;
		ack <= load;
	end
	// a released latch shows the inverse, never a stale word
	assign q = oe_n ? ~held : held;
endmodule // latch_glue
`default_nettype wire
